// File: mask_bank_pkg.sv
// Package of offsets, reset values and carrier types for the interrupt mask flag bank.
`default_nettype none
package mask_bank_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int NUM_REGS = 4;
    localparam int NUM_SRC = 32;
    localparam logic [7:0] OFS_MASK_LOW_0 = 8'hE4;
    localparam logic [7:0] OFS_MASK_HIGH_0 = 8'hE5;
    localparam logic [7:0] OFS_MASK_LOW_1 = 8'hE6;
    localparam logic [7:0] OFS_MASK_HIGH_1 = 8'hE7;
    localparam logic [7:0] MASK_RESET = 8'hFF;

    // ------------------------------------------------------------
    // Access kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_BIT,
        ACC_BYTE,
        ACC_WORD
    } access_kind_t;

    typedef struct packed {
        logic valid;
        logic write;
        access_kind_t kind;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [15:0] wdata;
    } mask_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
        logic hit;
    } mask_rsp_t;

endpackage
`default_nettype wire

// File: mask_byte_reg.sv
// One 8-bit mask register with bit and byte write ports.
`timescale 1ns/100ps
`default_nettype none
module mask_byte_reg
    import mask_bank_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Write controls
    input wire logic bit_we,
    input wire logic [2:0] bit_sel,
    input wire logic bit_val,
    input wire logic byte_we,
    input wire logic [7:0] byte_val,
    // Stored value
    output logic [7:0] value
);
    logic [7:0] value_reg;
    logic [7:0] value_next;

    always_comb
    begin
        value_next = value_reg;
        if (byte_we)
        begin
            value_next = byte_val;
        end
        else if (bit_we)
        begin
            value_next[bit_sel] = bit_val;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            value_reg <= MASK_RESET;
        end
        else
        begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;
endmodule
`default_nettype wire

// File: irq_mask_bank.sv
// Interrupt mask flag bank: four 8-bit mask registers and the servicing gate.
`timescale 1ns/100ps
`default_nettype none
module irq_mask_bank
    import mask_bank_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register access from the core
    input wire mask_req_t req,
    output mask_rsp_t rsp,
    // Request flags from the request flag registers
    input wire logic [NUM_SRC-1:0] req_flags,
    // Sources allowed on to the priority logic
    output logic [NUM_SRC-1:0] service_ok
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic [2:0] reg_index(input logic [7:0] a);
        logic [2:0] r;
        r = 3'h4;
        case (a)
            OFS_MASK_LOW_0: r = 3'h0;
            OFS_MASK_HIGH_0: r = 3'h1;
            OFS_MASK_LOW_1: r = 3'h2;
            OFS_MASK_HIGH_1: r = 3'h3;
            default: r = 3'h4;
        endcase
        return r;
    endfunction

    logic [2:0] idx;
    logic idx_hit;
    logic word_ok;
    logic [7:0] mask_q [NUM_REGS];
    logic [NUM_SRC-1:0] mask_flat;
    logic [NUM_REGS-1:0] bit_we;
    logic [NUM_REGS-1:0] byte_we;
    logic [7:0] byte_val [NUM_REGS];

    assign idx = reg_index(req.addr);
    assign idx_hit = (idx != 3'h4);
    // A word access must name the low register of a pair.
    assign word_ok = idx_hit && (idx[0] == 1'b0);

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++)
        begin : g_reg
            always_comb
            begin
                bit_we[g] = 1'b0;
                byte_we[g] = 1'b0;
                byte_val[g] = req.wdata[7:0];
                if (req.valid && req.write && idx_hit)
                begin
                    case (req.kind)
                        ACC_BIT: bit_we[g] = (idx == 3'(g));
                        ACC_BYTE: byte_we[g] = (idx == 3'(g));
                        ACC_WORD:
                        begin
                            // Both halves land in the same cycle.
                            byte_we[g] = word_ok && (idx[2:1] == 2'(g / 2));
                            byte_val[g] = (g % 2 == 1) ? req.wdata[15:8] : req.wdata[7:0];
                        end
                        default: byte_we[g] = 1'b0;
                    endcase
                end
            end

            mask_byte_reg mask_byte_reg_i (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .bit_we(bit_we[g]),
                .bit_sel(req.bit_sel),
                .bit_val(req.wdata[0]),
                .byte_we(byte_we[g]),
                .byte_val(byte_val[g]),
                .value(mask_q[g])
            );
            assign mask_flat[g*8 +: 8] = mask_q[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // Read response and servicing gate
    // ------------------------------------------------------------
    mask_rsp_t rsp_reg;
    mask_rsp_t rsp_next;
    logic [NUM_SRC-1:0] ok_reg;
    logic [NUM_SRC-1:0] ok_next;

    always_comb
    begin
        rsp_next = '0;
        rsp_next.valid = req.valid;
        if (req.valid)
        begin
            if (req.kind == ACC_WORD)
            begin
                rsp_next.hit = word_ok;
                if (word_ok)
                begin
                    rsp_next.rdata = {mask_q[{idx[1], 1'b1}], mask_q[{idx[1], 1'b0}]};
                end
            end
            else
            begin
                rsp_next.hit = idx_hit;
                if (idx_hit && req.kind == ACC_BIT)
                begin
                    rsp_next.rdata = {15'h0, mask_q[idx[1:0]][req.bit_sel]};
                end
                else if (idx_hit)
                begin
                    rsp_next.rdata = {8'h00, mask_q[idx[1:0]]};
                end
            end
        end
        // Flags pass through unchanged; masked ones simply never reach servicing.
        ok_next = req_flags & ~mask_flat;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rsp_reg <= '0;
            ok_reg <= '0;
        end
        else
        begin
            rsp_reg <= rsp_next;
            ok_reg <= ok_next;
        end
    end

    assign rsp = rsp_reg;
    assign service_ok = ok_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_gate;
        @(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> service_ok == ($past(req_flags) & ~$past(mask_flat));
    endproperty
    a_gate: assert property (p_gate) else $error("service gate mismatch");

    property p_masked_blocked;
        @(posedge core_clk) disable iff (sys_rst)
        mask_flat[0] |=> !service_ok[0];
    endproperty
    a_masked_blocked: assert property (p_masked_blocked) else $error("masked source served");

    property p_bit_write;
        @(posedge core_clk) disable iff (sys_rst)
        (req.valid && req.write && req.kind == ACC_BIT && req.addr == OFS_MASK_LOW_1)
        |=> mask_q[2][$past(req.bit_sel)] == $past(req.wdata[0])
            && (mask_q[3] == $past(mask_q[3]));
    endproperty
    a_bit_write: assert property (p_bit_write) else $error("bit write wrong");

    // A bit write must leave the seven neighbouring bits of its register alone.
    property p_bit_keep;
        @(posedge core_clk) disable iff (sys_rst)
        (req.valid && req.write && req.kind == ACC_BIT && req.addr == OFS_MASK_LOW_1)
        |=> (mask_q[2] & ~(8'h01 << $past(req.bit_sel)))
            == ($past(mask_q[2]) & ~(8'h01 << $past(req.bit_sel)));
    endproperty
    a_bit_keep: assert property (p_bit_keep) else $error("bit write disturbed neighbours");

    property p_byte_write;
        @(posedge core_clk) disable iff (sys_rst)
        (req.valid && req.write && req.kind == ACC_BYTE && req.addr == OFS_MASK_HIGH_1)
        |=> mask_q[3] == $past(req.wdata[7:0]);
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("byte write wrong");

    property p_word_write;
        @(posedge core_clk) disable iff (sys_rst)
        (req.valid && req.write && req.kind == ACC_WORD && req.addr == OFS_MASK_LOW_1)
        |=> {mask_q[3], mask_q[2]} == $past(req.wdata);
    endproperty
    a_word_write: assert property (p_word_write) else $error("word write wrong");

    // A word aimed at the high register of a pair is refused and changes nothing.
    property p_word_refused;
        @(posedge core_clk) disable iff (sys_rst)
        (req.valid && req.write && req.kind == ACC_WORD && req.addr == OFS_MASK_HIGH_0)
        |=> (mask_q[0] == $past(mask_q[0])) && (mask_q[1] == $past(mask_q[1]));
    endproperty
    a_word_refused: assert property (p_word_refused) else $error("refused word wrote");

    property p_word_read;
        @(posedge core_clk) disable iff (sys_rst)
        (req.valid && !req.write && req.kind == ACC_WORD && req.addr == OFS_MASK_LOW_0)
        |=> rsp.rdata == {$past(mask_q[1]), $past(mask_q[0])};
    endproperty
    a_word_read: assert property (p_word_read) else $error("word read wrong");

    property p_reset_ones;
        @(posedge core_clk)
        $fell(sys_rst) |-> mask_flat == {NUM_SRC{1'b1}};
    endproperty
    a_reset_ones: assert property (p_reset_ones) else $error("reset value wrong");

    c_word: cover property (@(posedge core_clk) req.valid && req.kind == ACC_WORD && word_ok);
    c_bit: cover property (@(posedge core_clk) req.valid && req.write && req.kind == ACC_BIT);
    c_serve: cover property (@(posedge core_clk) |service_ok);
    c_reset: cover property (@(posedge core_clk) $fell(sys_rst));
    c_refused: cover property (@(posedge core_clk) req.valid && !idx_hit);
endmodule
`default_nettype wire

// File: test_irq_mask_bank.sv
// Self-checking testbench for the interrupt mask flag bank.
`timescale 1ns/100ps
`default_nettype none
module test_irq_mask_bank
    import mask_bank_pkg::*;
;
    logic core_clk;
    logic sys_rst;
    mask_req_t req;
    mask_rsp_t rsp;
    logic [NUM_SRC-1:0] req_flags;
    logic [NUM_SRC-1:0] service_ok;
    logic [31:0] mdl;
    int failures;
    int tests_run;

    irq_mask_bank irq_mask_bank_i (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .req(req),
        .rsp(rsp),
        .req_flags(req_flags),
        .service_ok(service_ok)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            tests_run++;
            if (seen !== exp)
            begin
                failures++;
                $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
            end
        end
    endtask

    // Called at a falling edge; the answer is judged one cycle after the request.
    // One idle cycle follows, so the next call never raises valid in the step it fell.
    task automatic acc(input logic wr, input access_kind_t k, input logic [7:0] a,
                       input logic [2:0] b, input logic [15:0] d, input logic h,
                       input logic [15:0] e);
        begin
            req = '{valid: 1'b1, write: wr, kind: k, addr: a, bit_sel: b, wdata: d};
            @(negedge core_clk);
            req = '0;
            chk({31'h0, rsp.valid}, 32'h1);
            chk({31'h0, rsp.hit}, {31'h0, h});
            if (!wr)
                chk({16'h0, rsp.rdata}, {16'h0, e});
            @(negedge core_clk);
            chk({31'h0, rsp.valid}, 32'h0);
        end
    endtask

    task automatic rd_all();
        begin
            for (int i = 0; i < 4; i++)
                acc(1'b0, ACC_BYTE, OFS_MASK_LOW_0 + 8'(i), 3'h0, 16'h0, 1'b1, {8'h0, mdl[8*i +: 8]});
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        begin
            mdl = {4{MASK_RESET}};
            rd_all();
            req_flags = '1;
            @(negedge core_clk);
            chk(service_ok, 32'h0);
        end
    endtask

    task automatic t_bytes();
        logic [7:0] v [4] = '{8'h5A, 8'hC3, 8'h0F, 8'h81};
        begin
            for (int i = 0; i < 4; i++)
            begin
                acc(1'b1, ACC_BYTE, OFS_MASK_LOW_0 + 8'(i), 3'h0, {8'hEE, v[i]}, 1'b1, 16'h0);
                mdl[8*i +: 8] = v[i];
            end
            rd_all();
        end
    endtask

    task automatic t_bits();
        begin
            for (int b = 0; b < 8; b++)
            begin
                acc(1'b1, ACC_BIT, OFS_MASK_LOW_1, 3'(b), {15'h7FFF, ~mdl[16+b]}, 1'b1, 16'h0);
                mdl[16+b] = ~mdl[16+b];
                acc(1'b0, ACC_BIT, OFS_MASK_LOW_1, 3'(b), 16'h0, 1'b1, {15'h0, mdl[16+b]});
            end
            rd_all();
        end
    endtask

    task automatic t_word();
        begin
            acc(1'b1, ACC_WORD, OFS_MASK_LOW_0, 3'h0, 16'h1234, 1'b1, 16'h0);
            acc(1'b1, ACC_WORD, OFS_MASK_LOW_1, 3'h0, 16'hBEEF, 1'b1, 16'h0);
            mdl = 32'hBEEF_1234;
            acc(1'b1, ACC_WORD, OFS_MASK_HIGH_0, 3'h0, 16'h0000, 1'b0, 16'h0);
            acc(1'b1, ACC_BYTE, 8'hE3, 3'h0, 16'h0000, 1'b0, 16'h0);
            acc(1'b0, ACC_BYTE, 8'hE8, 3'h0, 16'h0, 1'b0, 16'h0);
            acc(1'b0, ACC_WORD, OFS_MASK_HIGH_1, 3'h0, 16'h0, 1'b0, 16'h0);
            acc(1'b0, ACC_WORD, OFS_MASK_LOW_0, 3'h0, 16'h0, 1'b1, 16'h1234);
            acc(1'b0, ACC_WORD, OFS_MASK_LOW_1, 3'h0, 16'h0, 1'b1, 16'hBEEF);
            rd_all();
        end
    endtask

    // The output is registered, so each check waits one full cycle after the change.
    task automatic t_gate(input logic [31:0] m, input logic [31:0] f);
        begin
            acc(1'b1, ACC_WORD, OFS_MASK_LOW_0, 3'h0, m[15:0], 1'b1, 16'h0);
            acc(1'b1, ACC_WORD, OFS_MASK_LOW_1, 3'h0, m[31:16], 1'b1, 16'h0);
            mdl = m;
            req_flags = f;
            @(negedge core_clk);
            chk(service_ok, f & ~m);
            req_flags = ~f;
            @(negedge core_clk);
            chk(service_ok, ~f & ~m);
        end
    endtask

    task automatic t_rerst();
        begin
            sys_rst = 1'b1;
            repeat (2) @(negedge core_clk);
            chk(service_ok, 32'h0);
            sys_rst = 1'b0;
            req_flags = '1;
            t_reset();
        end
    endtask

    task automatic summarize();
        begin
            $display("Comparisons %0d, mismatches %0d", tests_run, failures);
            if (failures == 0 && tests_run > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    initial
    begin
        #50000;
        failures++;
        summarize();
    end

    initial
    begin
        failures = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        req = '0;
        req_flags = '0;
        mdl = '0;
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        t_reset();
        t_bytes();
        t_bits();
        t_word();
        t_gate(32'h0F0F_3C96, 32'hFFFF_5A5A);
        t_gate(32'h0000_0000, 32'h8000_0001);
        t_rerst();
        summarize();
    end
endmodule
`default_nettype wire
